// ===== crf_dev_model.sv
// behavioural model of the device ring registers and ring memory
`include "crf_regs.vh"
module crf_dev_model (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic srst_i,
    // register port
    input wire logic dev_req_i,
    input wire logic dev_we_i,
    input wire logic [7:0] dev_addr_i,
    input wire logic [31:0] dev_wdata_i,
    output logic [31:0] dev_rdata_o,
    output logic dev_ack_o,
    // ring memory port
    input wire logic mem_req_i,
    input wire logic [31:0] mem_addr_i,
    input wire logic [31:0] mem_wdata_i,
    output logic mem_ack_o,
    // answer after four cycles
    input wire logic slow_i
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [0:1023];
    logic [31:0] start_reg, rd_val;
    logic [31:0] rpt_slot_reg;
    logic [18:0] head_reg;
    logic [10:0] wrap_reg;
    logic [20:0] tail_reg;
    logic [9:0] pages_reg;
    logic [1:0] rpt_reg, cnt_reg, tick_reg;
    logic valid_reg, claim_reg, mutex_reg;
    wire go = !slow_i || cnt_reg == 2'h3;
    wire [19:0] head_nx = {1'b0, head_reg} + 20'h1;
    wire at_end = head_nx == {pages_reg, 10'h0};
    wire [18:0] head_new = at_end ? 19'h0 : head_nx[18:0];
    // 64KB crossings in mode 1, 128KB in modes 2 and 3
    wire crossed = rpt_reg != 2'h0 && head_new[13:0] == 14'h0 && (!rpt_reg[1] || !head_new[14]);
    always_comb begin
        case (dev_addr_i)
            `CRF_DEV_TAIL: rd_val = {11'h0, tail_reg[20:1], claim_reg & mutex_reg};
            `CRF_DEV_HEAD: rd_val = {wrap_reg, head_reg, 2'h0};
            `CRF_DEV_START: rd_val = start_reg;
            `CRF_DEV_CTL: rd_val = {11'h0, pages_reg[8:0] - 9'h1, 9'h0, rpt_reg, valid_reg};
            default: rd_val = {31'h0, mutex_reg};
        endcase
    end
    always @(posedge ref_clk_i) begin
        dev_ack_o <= 1'b0;
        mem_ack_o <= 1'b0;
        // released bus inverts every cycle, showing the last value only every other cycle
        dev_rdata_o <= ~dev_rdata_o;
        cnt_reg <= (dev_req_i || mem_req_i) ? cnt_reg + 2'h1 : 2'h0;
        tick_reg <= tick_reg + 2'h1;
        if (valid_reg && {head_reg, 2'h0} != tail_reg && tick_reg == 2'h0) begin
            head_reg <= head_new;
            wrap_reg <= wrap_reg + {10'h0, at_end};
            // whole head word to the fixed status slot
            if (crossed) begin
                rpt_slot_reg <= {wrap_reg + {10'h0, at_end}, head_new, 2'h0};
            end
        end
        if (dev_req_i && !dev_ack_o && go) begin
            dev_ack_o <= 1'b1;
            dev_rdata_o <= rd_val;
            if (!dev_we_i && dev_addr_i == `CRF_DEV_TAIL && mutex_reg) begin
                claim_reg <= 1'b1;
            end
            if (dev_we_i) begin
                case (dev_addr_i)
                    `CRF_DEV_TAIL: begin
                        tail_reg <= {dev_wdata_i[20:1], 1'b0};
                        claim_reg <= 1'b0;
                    end
                    `CRF_DEV_HEAD: begin
                        head_reg <= dev_wdata_i[20:2];
                        wrap_reg <= dev_wdata_i[31:21];
                    end
                    `CRF_DEV_START: start_reg <= dev_wdata_i;
                    `CRF_DEV_CTL: begin
                        valid_reg <= dev_wdata_i[0];
                        rpt_reg <= dev_wdata_i[2:1];
                        pages_reg <= {1'b0, dev_wdata_i[20:12]} + 10'h1;
                    end
                    `CRF_DEV_MODE: mutex_reg <= dev_wdata_i[0];
                    default: ;
                endcase
            end
        end
        if (mem_req_i && !mem_ack_o && go) begin
            mem_ack_o <= 1'b1;
            // one page ring only, wider rings alias
            mem[mem_addr_i[11:2]] <= mem_wdata_i;
        end
        if (srst_i) begin
            valid_reg <= 1'b0;
            claim_reg <= 1'b0;
            mutex_reg <= 1'b0;
            rpt_slot_reg <= 32'h0;
            cnt_reg <= 2'h0;
            tick_reg <= 2'h0;
        end
    end
endmodule // crf_dev_model

// ===== crf_host_ctrl.v
// host controller feeding commands into a device command ring
//
// Local design decisions: the register addresses and the Wishbone slave port.
`include "crf_regs.vh"
module crf_host_ctrl #(
    parameter OFF_W = 20
) (
    // clock and reset
    input wire ref_clk_i,
    input wire srst_i,
    // wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // device register access
    output reg dev_req_o,
    output reg dev_we_o,
    output reg [7:0] dev_addr_o,
    output reg [31:0] dev_wdata_o,
    input wire [31:0] dev_rdata_i,
    input wire dev_ack_i,
    // ring memory write port
    output reg mem_req_o,
    output reg [31:0] mem_addr_o,
    output reg [31:0] mem_wdata_o,
    input wire mem_ack_i
);
    localparam S_IDLE = 4'b0001;
    localparam S_NEXT = 4'b0010;
    localparam S_DEV = 4'b0100;
    localparam S_MEM = 4'b1000;

    reg [3:0] state_reg;
    reg [2:0] op_reg;
    reg [1:0] step_reg;
    reg [31:0] start_reg;
    reg [9:0] pages_reg;
    reg [1:0] rpt_mode_reg;
    reg mutex_en_reg;
    reg valid_reg;
    reg owned_reg;
    reg stall_reg;
    reg cmd_done_reg;
    reg [31:0] cmd_data_reg;
    reg [31:0] rd_reg;
    reg [OFF_W-1:0] tail_dw_reg;
    reg [OFF_W-1:0] tail_sub_reg;
    reg [OFF_W-1:0] head_dw_reg;
    reg [10:0] wrap_reg;

    wire wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wb_wr = wb_hit & wb_we_i & (&wb_sel_i);
    wire is_cmd = (wb_adr_i == `CRF_WB_CMD);
    wire idle = state_reg[0];
    // ring length in dwords from 4KB pages
    wire [OFF_W-1:0] len_dw = {pages_reg, {`CRF_PAGE_DW_SHIFT{1'b0}}};
    // wrap tail back to the ring start
    wire [OFF_W-1:0] tail_inc = tail_dw_reg + {{(OFF_W-1){1'b0}}, 1'b1};
    // each cmd dword is whole, so a wrap lands between commands
    wire [OFF_W-1:0] tail_nxt = (tail_inc == len_dw) ? {OFF_W{1'b0}} : tail_inc;
    // occupancy, counting a wrapped tail as ahead of head
    wire [OFF_W-1:0] used_dw = (tail_dw_reg >= head_dw_reg) ? (tail_dw_reg - head_dw_reg)
                                                            : (tail_dw_reg + len_dw - head_dw_reg);
    // always leave one qword free so full never looks empty
    // tail never laps head, so head never passes it
    wire room = ((used_dw + {{(OFF_W-3){1'b0}}, 3'h4}) <= len_dw);
    // length field holds pages minus one, at most 511
    wire [9:0] pages_m1 = pages_reg - 10'h001;
    // control word carries every field whatever valid is
    wire [31:0] ctl_word = {11'h000, pages_m1[8:0], 9'h000, rpt_mode_reg, valid_reg};

    // wishbone register side and read mux
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            // cmd writes hold ack until the dword has landed
            // partial-select cmd writes are acked at once and dropped
            wb_ack_o <= wb_hit & (~(is_cmd & wb_wr) | cmd_done_reg);
            case (wb_adr_i)
                `CRF_WB_CTRL: wb_dat_o <= {26'h0, mutex_en_reg, rpt_mode_reg, 3'h0};
                `CRF_WB_START: wb_dat_o <= start_reg;
                `CRF_WB_PAGES: wb_dat_o <= {22'h0, pages_reg};
                `CRF_WB_STATUS: wb_dat_o <= {27'h0, stall_reg, (tail_sub_reg == head_dw_reg),
                                             owned_reg, valid_reg, ~idle};
                `CRF_WB_HEAD: wb_dat_o <= {wrap_reg, head_dw_reg[18:0], 2'h0};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // sequencer
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            state_reg <= S_IDLE;
            op_reg <= 3'h0;
            step_reg <= 2'h0;
            start_reg <= 32'h0000_0000;
            pages_reg <= 10'h001;
            rpt_mode_reg <= 2'h0;
            mutex_en_reg <= 1'b0;
            valid_reg <= 1'b0;
            owned_reg <= 1'b0;
            stall_reg <= 1'b0;
            cmd_done_reg <= 1'b0;
            cmd_data_reg <= 32'h0000_0000;
            rd_reg <= 32'h0000_0000;
            tail_dw_reg <= {OFF_W{1'b0}};
            tail_sub_reg <= {OFF_W{1'b0}};
            head_dw_reg <= {OFF_W{1'b0}};
            wrap_reg <= 11'h000;
            dev_req_o <= 1'b0;
            dev_we_o <= 1'b0;
            dev_addr_o <= 8'h00;
            dev_wdata_o <= 32'h0000_0000;
            mem_req_o <= 1'b0;
            mem_addr_o <= 32'h0000_0000;
            mem_wdata_o <= 32'h0000_0000;
        end else begin
            cmd_done_reg <= 1'b0;
            case (state_reg)
                S_IDLE: begin
                    if (wb_wr & ~cmd_done_reg) begin
                        case (wb_adr_i)
                            `CRF_WB_CTRL: begin
                                rpt_mode_reg <= wb_dat_i[4:3];
                                mutex_en_reg <= wb_dat_i[5];
                                if (wb_dat_i[2:0] != 3'h0) begin
                                    op_reg <= wb_dat_i[2:0];
                                    step_reg <= 2'h0;
                                    state_reg <= S_NEXT;
                                end
                            end
                            // low 12 bits forced so start stays page aligned
                            `CRF_WB_START: start_reg <= {wb_dat_i[31:12], 12'h000};
                            `CRF_WB_PAGES: pages_reg <= (wb_dat_i[9:0] == 10'h000) ? 10'h001 :
                                                       (wb_dat_i[9] ? 10'h200 : wb_dat_i[9:0]);
                            `CRF_WB_CMD: begin
                                cmd_data_reg <= wb_dat_i;
                                op_reg <= `CRF_OP_CMD;
                                step_reg <= 2'h0;
                                state_reg <= S_NEXT;
                            end
                            default: state_reg <= S_IDLE;
                        endcase
                    end
                end
                S_NEXT: begin
                    state_reg <= S_DEV;
                    step_reg <= step_reg + 2'h1;
                    dev_req_o <= 1'b1;
                    dev_we_o <= 1'b1;
                    case (op_reg)
                        `CRF_OP_INIT: begin
                            // every field programmed with valid held clear
                            valid_reg <= 1'b0;
                            tail_dw_reg <= {OFF_W{1'b0}};
                            tail_sub_reg <= {OFF_W{1'b0}};
                            head_dw_reg <= {OFF_W{1'b0}};
                            case (step_reg)
                                2'h0: begin
                                    dev_addr_o <= `CRF_DEV_MODE;
                                    dev_wdata_o <= {31'h0, mutex_en_reg};
                                end
                                2'h1: begin
                                    dev_addr_o <= `CRF_DEV_CTL;
                                    dev_wdata_o <= {ctl_word[31:1], 1'b0};
                                end
                                2'h2: begin
                                    dev_addr_o <= `CRF_DEV_START;
                                    dev_wdata_o <= start_reg;
                                end
                                default: begin
                                    // head written explicitly, tail follows at zero
                                    dev_addr_o <= `CRF_DEV_HEAD;
                                    dev_wdata_o <= 32'h0000_0000;
                                    op_reg <= `CRF_OP_SUBMIT;
                                    step_reg <= 2'h1;
                                end
                            endcase
                        end
                        `CRF_OP_ENABLE: begin
                            // enable whatever head and tail already hold
                            valid_reg <= 1'b1;
                            dev_addr_o <= `CRF_DEV_CTL;
                            dev_wdata_o <= {ctl_word[31:1], 1'b1};
                            op_reg <= 3'h0;
                        end
                        `CRF_OP_DISABLE, `CRF_OP_CMD: begin
                            if (step_reg == 2'h0) begin
                                dev_we_o <= 1'b0;
                                dev_addr_o <= `CRF_DEV_HEAD;
                            end else if (op_reg == `CRF_OP_DISABLE) begin
                                // disable only once head has caught tail
                                if (head_dw_reg == tail_sub_reg) begin
                                    valid_reg <= 1'b0;
                                    dev_addr_o <= `CRF_DEV_CTL;
                                    dev_wdata_o <= {ctl_word[31:1], 1'b0};
                                    op_reg <= 3'h0;
                                end else begin
                                    dev_we_o <= 1'b0;
                                    dev_addr_o <= `CRF_DEV_HEAD;
                                    step_reg <= 2'h1;
                                end
                            end else if (room) begin
                                // command dword goes to memory before any tail write
                                dev_req_o <= 1'b0;
                                mem_req_o <= 1'b1;
                                mem_addr_o <= start_reg + {10'h000, tail_dw_reg, 2'h0};
                                mem_wdata_o <= cmd_data_reg;
                                tail_dw_reg <= tail_nxt;
                                stall_reg <= 1'b0;
                                op_reg <= 3'h0;
                                state_reg <= S_MEM;
                            end else begin
                                // no room: keep polling head, bus stays stalled
                                stall_reg <= 1'b1;
                                dev_we_o <= 1'b0;
                                dev_addr_o <= `CRF_DEV_HEAD;
                                step_reg <= 2'h1;
                            end
                        end
                        `CRF_OP_ACQUIRE: begin
                            if (step_reg == 2'h0) begin
                                // claim attempt is a plain tail read
                                dev_we_o <= 1'b0;
                                dev_addr_o <= `CRF_DEV_TAIL;
                            end else begin
                                // claim reads zero when mutex is off
                                owned_reg <= ~rd_reg[`CRF_CLAIM_BIT] & mutex_en_reg;
                                dev_req_o <= 1'b0;
                                dev_we_o <= 1'b0;
                                state_reg <= S_IDLE;
                            end
                        end
                        `CRF_OP_SUBMIT: begin
                            if ((step_reg == 2'h0) && tail_dw_reg[0]) begin
                                // pad odd dword with a no-op to finish the qword
                                dev_req_o <= 1'b0;
                                mem_req_o <= 1'b1;
                                mem_addr_o <= start_reg + {10'h000, tail_dw_reg, 2'h0};
                                mem_wdata_o <= `CRF_NOOP_CMD;
                                tail_dw_reg <= tail_nxt;
                                state_reg <= S_MEM;
                            end else begin
                                // a wrapped tail is simply a lower value
                                // the tail write also drops our claim
                                dev_addr_o <= `CRF_DEV_TAIL;
                                dev_wdata_o <= {11'h000, tail_dw_reg[18:0], 2'h0};
                                tail_sub_reg <= tail_dw_reg;
                                owned_reg <= 1'b0;
                                op_reg <= 3'h0;
                            end
                        end
                        default: begin
                            dev_req_o <= 1'b0;
                            dev_we_o <= 1'b0;
                            state_reg <= S_IDLE;
                        end
                    endcase
                end
                S_DEV: begin
                    if (dev_ack_i) begin
                        dev_req_o <= 1'b0;
                        rd_reg <= dev_rdata_i;
                        if (~dev_we_o && (dev_addr_o == `CRF_DEV_HEAD)) begin
                            // keep device head and wrap count for software
                            head_dw_reg <= {1'b0, dev_rdata_i[`CRF_WRAP_LO-1:`CRF_HEAD_LO]};
                            wrap_reg <= dev_rdata_i[31:`CRF_WRAP_LO];
                        end
                        state_reg <= (op_reg == 3'h0) ? S_IDLE : S_NEXT;
                    end
                end
                S_MEM: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        cmd_done_reg <= (op_reg == 3'h0);
                        state_reg <= (op_reg == 3'h0) ? S_IDLE : S_NEXT;
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end
endmodule // crf_host_ctrl

// ===== crf_host_ctrl_chk.sv
// assertion checker for the command ring host controller
`include "crf_regs.vh"
module crf_host_ctrl_chk (
    // clock and reset
    input wire ref_clk_i,
    input wire srst_i,
    // watched ports
    input wire wb_ack_o,
    input wire dev_req_o,
    input wire dev_we_o,
    input wire [7:0] dev_addr_o,
    input wire [31:0] dev_wdata_o,
    input wire dev_ack_i,
    input wire mem_req_o,
    input wire [31:0] mem_addr_o,
    input wire mem_ack_i
);
    timeunit 1ns;
    timeprecision 1ns;
    reg [2:0] seen_reg;
    wire wr = dev_req_o && dev_we_o;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (srst_i);
    // setup writes seen since reset
    always @(posedge ref_clk_i) begin
        if (srst_i) begin
            seen_reg <= 3'h0;
        end else if (wr && dev_ack_i) begin
            seen_reg <= seen_reg | {dev_addr_o == `CRF_DEV_TAIL, dev_addr_o == `CRF_DEV_HEAD,
                dev_addr_o == `CRF_DEV_START};
        end
    end
    AST_SETUP_FIRST: assert property (
        wr && dev_addr_o == `CRF_DEV_CTL && dev_wdata_o[0] |-> seen_reg == 3'h7) else $error("enable before setup");
    AST_START_ALIGN: assert property (
        wr && dev_addr_o == `CRF_DEV_START |-> dev_wdata_o[11:0] == 12'h0) else $error("start unaligned");
    AST_TAIL_QWORD: assert property (
        wr && dev_addr_o == `CRF_DEV_TAIL |-> dev_wdata_o[2:0] == 3'h0) else $error("tail not qword");
    AST_TAIL_LAST: assert property (
        wr && dev_addr_o == `CRF_DEV_TAIL |-> !mem_req_o) else $error("tail before data");
    AST_DEV_HOLD: assert property (
        dev_req_o && !dev_ack_i |=> dev_req_o && $stable(dev_addr_o) && $stable(dev_wdata_o))
        else $error("device request moved");
    AST_DEV_GAP: assert property (
        dev_req_o && dev_ack_i |=> !dev_req_o) else $error("device request held");
    AST_MEM_HOLD: assert property (
        mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_addr_o)) else $error("memory request moved");
    AST_ACK_PULSE: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack too long");
endmodule // crf_host_ctrl_chk
bind crf_host_ctrl crf_host_ctrl_chk crf_host_ctrl_chk_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i),
    .wb_ack_o(wb_ack_o), .dev_req_o(dev_req_o), .dev_we_o(dev_we_o), .dev_addr_o(dev_addr_o),
    .dev_wdata_o(dev_wdata_o), .dev_ack_i(dev_ack_i), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
    .mem_ack_i(mem_ack_i));

// ===== crf_regs.vh
// constants for the command ring host controller
// What this block does
// - host programs start, length, head and tail before setting valid
// - host clears valid on disable only after polling head equal to tail; init writes it clear without polling
// - host places the ring on a 4KB aligned start address
// - device never clears head on enable, so host writes head first
// - host advances tail in qwords, padding last qword with a no-op
// - tail below previous tail means wrap; keep one qword free
// - host lets a wrap fall only between whole commands
// - host writes commands, pads, and only then writes tail
// - head must not exceed tail when both share a cache line
// - host reads tail first, owns ring if claim was clear, releases by tail write
`ifndef CRF_REGS_VH
`define CRF_REGS_VH
// device ring registers, byte addresses
`define CRF_DEV_TAIL 8'h00
`define CRF_DEV_HEAD 8'h04
`define CRF_DEV_START 8'h08
`define CRF_DEV_CTL 8'h0c
`define CRF_DEV_MODE 8'h10
// device field positions
`define CRF_CLAIM_BIT 0
`define CRF_VALID_BIT 0
`define CRF_RPT_LO 1
`define CRF_LEN_LO 12
`define CRF_HEAD_LO 2
`define CRF_WRAP_LO 21
`define CRF_MUTEX_BIT 0
// own wishbone registers, byte addresses
`define CRF_WB_CTRL 8'h00
`define CRF_WB_START 8'h04
`define CRF_WB_PAGES 8'h08
`define CRF_WB_CMD 8'h0c
`define CRF_WB_STATUS 8'h10
`define CRF_WB_HEAD 8'h14
// operation codes in ctrl[2:0]
`define CRF_OP_INIT 3'h1
`define CRF_OP_ENABLE 3'h2
`define CRF_OP_DISABLE 3'h3
`define CRF_OP_ACQUIRE 3'h4
`define CRF_OP_SUBMIT 3'h5
`define CRF_OP_CMD 3'h6
// no-op command used for qword padding
`define CRF_NOOP_CMD 32'h0000_0000
`define CRF_PAGE_DW_SHIFT 10
`endif

// ===== tb_top.sv
// self-checking bench for the command ring host controller
`include "crf_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk_i, srst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, slow;
    logic [7:0] wb_adr_i, dev_addr;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, dev_wdata, dev_rdata, mem_addr, mem_wdata;
    logic dev_req, dev_we, dev_ack, mem_req, mem_ack;
    int num_errors, comparisons, cycles;
    crf_host_ctrl crf_host_ctrl_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .dev_req_o(dev_req), .dev_we_o(dev_we), .dev_addr_o(dev_addr), .dev_wdata_o(dev_wdata),
        .dev_rdata_i(dev_rdata), .dev_ack_i(dev_ack), .mem_req_o(mem_req), .mem_addr_o(mem_addr),
        .mem_wdata_o(mem_wdata), .mem_ack_i(mem_ack));
    crf_dev_model crf_dev_model_i (.ref_clk_i(ref_clk_i), .srst_i(srst_i), .dev_req_i(dev_req), .dev_we_i(dev_we),
        .dev_addr_i(dev_addr), .dev_wdata_i(dev_wdata), .dev_rdata_o(dev_rdata), .dev_ack_o(dev_ack),
        .mem_req_i(mem_req), .mem_addr_i(mem_addr), .mem_wdata_i(mem_wdata), .mem_ack_o(mem_ack), .slow_i(slow));
    initial begin
        ref_clk_i = 1'b0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    task automatic end_of_test();
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask
    // hold the request until ack is sampled, then release
    task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel,
        output logic [31:0] d);
        @(posedge ref_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        wb_sel_i <= sel;
        do @(posedge ref_clk_i); while (wb_ack_o !== 1'b1);
        d = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        xfer(1'b1, adr, dat, 4'hf, d);
    endtask
    task automatic rd(input logic [7:0] adr, input logic [31:0] exp, input string what);
        logic [31:0] d;
        xfer(1'b0, adr, 32'h0, 4'hf, d);
        chk(d, exp, what);
    endtask
    // mutex on, report mode 1
    task automatic op(input logic [2:0] code);
        logic [31:0] d;
        wr(`CRF_WB_CTRL, {26'h0, 3'b101, code});
        d = 32'h1;
        for (int n = 0; n < 300 && d[0] !== 1'b0; n++) xfer(1'b0, `CRF_WB_STATUS, 32'h0, 4'hf, d);
        chk({31'h0, d[0]}, 32'h0, "op stuck");
    endtask
    task automatic t_map();
        logic [31:0] d;
        rd(`CRF_WB_PAGES, 32'h1, "pages reset");
        wr(`CRF_WB_PAGES, 32'h0);
        rd(`CRF_WB_PAGES, 32'h1, "pages zero");
        wr(`CRF_WB_PAGES, 32'h258);
        rd(`CRF_WB_PAGES, 32'h200, "pages max");
        xfer(1'b1, `CRF_WB_PAGES, 32'h5, 4'h3, d);
        rd(`CRF_WB_PAGES, 32'h200, "partial sel");
        wr(`CRF_WB_START, 32'h0004_0abc);
        rd(`CRF_WB_START, 32'h0004_0000, "start");
        rd(8'h3c, 32'h0, "unmapped");
        wr(`CRF_WB_PAGES, 32'h1);
    endtask
    task automatic t_init();
        op(`CRF_OP_INIT);
        chk({31'h0, crf_dev_model_i.valid_reg}, 32'h0, "valid early");
        chk({13'h0, crf_dev_model_i.head_reg}, 32'h0, "head set");
        op(`CRF_OP_ENABLE);
        chk({31'h0, crf_dev_model_i.valid_reg}, 32'h1, "valid");
        chk({22'h0, crf_dev_model_i.pages_reg}, 32'h1, "pages");
        chk(crf_dev_model_i.start_reg, 32'h0004_0000, "dev start");
        chk({30'h0, crf_dev_model_i.rpt_reg}, 32'h1, "report mode");
        rd(`CRF_WB_STATUS, 32'ha, "status on");
        rd(`CRF_WB_CTRL, 32'h28, "ctrl");
    endtask
    task automatic t_claim();
        op(`CRF_OP_ACQUIRE);
        rd(`CRF_WB_STATUS, 32'he, "owned");
        op(`CRF_OP_ACQUIRE);
        rd(`CRF_WB_STATUS, 32'ha, "held elsewhere");
    endtask
    task automatic t_cmd();
        for (int i = 0; i < 3; i++) wr(`CRF_WB_CMD, 32'hc0de_0000 + i);
        op(`CRF_OP_SUBMIT);
        for (int i = 0; i < 4; i++) chk(crf_dev_model_i.mem[i], i < 3 ? 32'hc0de_0000 + i : `CRF_NOOP_CMD, "pad");
        chk({11'h0, crf_dev_model_i.tail_reg}, 32'h10, "tail");
        chk({31'h0, crf_dev_model_i.claim_reg}, 32'h0, "release");
    endtask
    task automatic t_wrap();
        slow <= 1'b1;
        for (int k = 0; k < 12; k++) begin
            for (int i = 0; i < 100; i++) wr(`CRF_WB_CMD, 32'h1000_0000 + k * 100 + i);
            op(`CRF_OP_SUBMIT);
        end
        slow <= 1'b0;
        chk(crf_dev_model_i.mem[179], 32'h1000_04af, "wrapped data");
        chk({11'h0, crf_dev_model_i.tail_reg}, 32'h2d0, "wrapped tail");
    endtask
    task automatic t_off();
        op(`CRF_OP_DISABLE);
        chk({31'h0, crf_dev_model_i.valid_reg}, 32'h0, "disabled");
        chk({13'h0, crf_dev_model_i.head_reg}, 32'hb4, "empty");
        rd(`CRF_WB_HEAD, {11'h1, 19'hb4, 2'h0}, "head word");
        chk(crf_dev_model_i.rpt_slot_reg, {11'h1, 19'h0, 2'h0}, "report slot");
    endtask
    // timeout
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 90000) begin
            num_errors++;
            $display("BAD %0t timeout", $time);
            end_of_test();
        end
    end
    initial begin
        srst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        slow = 1'b0;
        num_errors = 0;
        comparisons = 0;
        cycles = 0;
        repeat (5) @(posedge ref_clk_i);
        srst_i <= 1'b0;
        t_map();
        t_init();
        t_claim();
        t_cmd();
        t_wrap();
        t_off();
        end_of_test();
    end
endmodule // tb_top
